// [src/emt_pkg.sv]
package emt_pkg;
	// -------------------------------------------------------------
	// register map, byte offsets within the slave window
	// -------------------------------------------------------------
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_GP_MODE = 8'h04;
	localparam logic [7:0] OFF_SYS_LIM = 8'h08;
	localparam logic [7:0] OFF_CPU_LIM = 8'h0C;
	localparam logic [7:0] OFF_REM_LIM = 8'h10;
	localparam logic [7:0] OFF_TOL = 8'h14;
	localparam logic [7:0] OFF_DLV = 8'h18;
	localparam logic [7:0] OFF_THR_DLV = 8'h1C;
	localparam logic [7:0] OFF_FAN_MODE = 8'h20;
	localparam logic [7:0] OFF_STATUS = 8'h24;
	localparam logic [7:0] OFF_BP = 8'h28;
	localparam logic [7:0] OFF_SPD = 8'h2C;
	localparam logic [7:0] OFF_FAN0 = 8'h30;
	localparam logic [7:0] OFF_FAN_END = 8'h4C;
	// -------------------------------------------------------------
	// reset values
	// -------------------------------------------------------------
	localparam logic [15:0] LIM_RST = 16'h3C00;
	localparam logic [7:0] TOL_RST = 8'h0A;
	localparam logic [31:0] BP_RST = 32'h4B46413C;
	localparam logic [7:0] SPD_RST = 8'hE4;
	localparam logic [3:0] GP_OUT_RST = 4'hF;
	localparam logic [13:0] FAN_RST = 14'h0000;
	// -------------------------------------------------------------
	// sizes and field positions
	// -------------------------------------------------------------
	localparam int NUM_RAILS = 7;
	localparam int NUM_FANS = 8;
	localparam int NUM_SW = 7;
	localparam int NUM_GP = 4;
	localparam int NUM_BP = 4;
	localparam int DLV_W = 6;
	localparam int FAN_W = 14;
	localparam int FAN_AW = 3;
	localparam int LIM_HI_LSB = 8;
	localparam int CTRL_THR_EN = 2;
	localparam int FAN_DLV_LSB = 8;
	localparam int FM_REM_EN = 7;
	localparam int FM_POL_LSB = 8;
	localparam int DLV_IRQ = 0;
	localparam int DLV_COM = 1;
	localparam int DLV_GP_LSB = 2;
	localparam int DLV_SYS = 0;
	localparam int DLV_CPU = 8;
	localparam int DLV_REM = 16;
	localparam int DLV_VOLT = 24;
	localparam int ST_LVL_LSB = 5;
	localparam int ST_RAIL_LSB = 8;
	localparam int ST_FAN_LSB = 16;
	localparam int ST_REQ_LSB = 24;
	localparam logic [31:0] PERCENT = 32'h00000064;
	// nominal rails in mV: +5, -5, +12, -12, +3.3, +2.5, processor (plain default)
	localparam logic [6:0][15:0] RAIL_NOM = {16'h0708, 16'h09C4, 16'h0CE4, 16'h2EE0,
		16'h2EE0, 16'h1388, 16'h1388};
	localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
	localparam logic [2:0] HSIZE_WORD = 3'b010;
	localparam logic HRESP_OKAY = 1'b0;
	// -------------------------------------------------------------
	// types
	// -------------------------------------------------------------
	typedef logic [6:0][15:0] emt_rails_t;
	typedef logic [7:0][7:0] emt_speeds_t;
	typedef enum logic [1:0] {BUS_IDLE = 2'b00, BUS_WAIT = 2'b01, BUS_DONE = 2'b10} emt_bus_t;
	typedef enum logic [1:0] {GP_NLOW = 2'b00, GP_NHIGH = 2'b01, GP_FLOW = 2'b10, GP_FHIGH = 2'b11} emt_gp_t;
	typedef enum logic [1:0] {IRQ_NONE = 2'b00, IRQ_10 = 2'b01, IRQ_11 = 2'b10} emt_irq_t;
	typedef enum logic [2:0] {RATIO_FULL = 3'b000, RATIO_3Q = 3'b001, RATIO_HALF = 3'b010,
		RATIO_QTR = 3'b011, RATIO_8TH = 3'b100} emt_ratio_t;
	// -------------------------------------------------------------
	// shared arithmetic
	// -------------------------------------------------------------
	function automatic logic out_of_range(logic [7:0] t, logic [7:0] lo, logic [7:0] hi);
		return (t < lo) || (t > hi);
	endfunction
	// deviation beyond tol percent of nominal
	function automatic logic rail_bad(logic [15:0] v, logic [15:0] nom, logic [7:0] tol);
		logic [31:0] diff;
		diff = (v > nom) ? 32'(v - nom) : 32'(nom - v);
		return (diff * PERCENT) > (32'(tol) * 32'(nom));
	endfunction
	function automatic logic gp_level(logic [1:0] mode, logic req);
		case (mode)
			GP_FLOW: return 1'b0;
			GP_FHIGH: return 1'b1;
			GP_NHIGH: return req;
			default: return !req;
		endcase
	endfunction
endpackage

// [src/emt_thr_if.sv]
interface emt_thr_if;
	logic en;
	logic [3:0][7:0] bp;
	logic [3:0][1:0] spd;
	logic [7:0] temp;
	logic [2:0] level;
	emt_pkg::emt_ratio_t ratio;
	modport ctl(output en, output bp, output spd, output temp, input level, input ratio);
	modport thr(input en, input bp, input spd, input temp, output level, output ratio);
endinterface

// [src/emt_fan_mem.sv]
module emt_fan_mem (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic wr_en_i,
	input wire logic [emt_pkg::FAN_AW-1:0] wr_addr_i,
	input wire logic [emt_pkg::FAN_W-1:0] wr_data_i,
	input wire logic [emt_pkg::FAN_AW-1:0] scan_addr_i,
	output logic [emt_pkg::FAN_W-1:0] scan_data_o,
	input wire logic [emt_pkg::FAN_AW-1:0] bus_addr_i,
	output logic [emt_pkg::FAN_W-1:0] bus_data_o
);
	import emt_pkg::*;
	logic [FAN_W-1:0] mem_r [NUM_FANS];
	// per-input word: minimum speed and delivery byte
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			for (int i = 0; i < NUM_FANS; i++) begin
				mem_r[i] <= FAN_RST;
			end
		end else if (wr_en_i) begin
			mem_r[wr_addr_i] <= wr_data_i;
		end
	end
	// two registered read ports: scanner and bus
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			scan_data_o <= FAN_RST;
			bus_data_o <= FAN_RST;
		end else begin
			scan_data_o <= mem_r[scan_addr_i];
			bus_data_o <= mem_r[bus_addr_i];
		end
	end
endmodule

// [src/emt_throttle.sv]
module emt_throttle (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	emt_thr_if.thr t
);
	import emt_pkg::*;
	logic [2:0] level_r;
	emt_ratio_t ratio_r;
	logic [2:0] lvl_dn;
	assign lvl_dn = level_r - 3'h1;
	assign t.level = level_r;
	assign t.ratio = ratio_r;
	// step level: one breakpoint up or down per clock
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			level_r <= 3'h0;
		end else if (!t.en) begin
			level_r <= 3'h0; // RULE16
		end else if (level_r < 3'(NUM_BP) && t.temp >= t.bp[level_r[1:0]]) begin
			level_r <= level_r + 3'h1; // RULE17 RULE18 RULE21
		end else if (level_r != 3'h0 && t.temp < t.bp[lvl_dn[1:0]]) begin
			level_r <= lvl_dn; // RULE19
		end
	end
	// level to clock ratio
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ratio_r <= RATIO_FULL;
		end else if (level_r == 3'h0) begin
			ratio_r <= RATIO_FULL;
		end else begin
			ratio_r <= emt_ratio_t'(3'(t.spd[lvl_dn[1:0]]) + 3'h1); // RULE20
		end
	end
	// -------------------------------------------------------------
	// checks
	// -------------------------------------------------------------
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);
	sequence s_up_cond;
		t.en && level_r == 3'h0 && t.temp >= t.bp[0];
	endsequence
	a_thr_off_idle: assert property (!t.en |=> level_r == 3'h0) else $error("level while disabled"); // RULE16
	a_thr_first_step: assert property (s_up_cond |=> level_r == 3'h1) else $error("no first step"); // RULE17
	a_thr_hold_band: assert property (t.en && level_r == 3'h1 && t.temp >= t.bp[0] && t.temp < t.bp[1]
		|=> level_r == 3'h1) else $error("hysteresis band left"); // RULE19
	a_thr_ratio_map: assert property (s_up_cond ##1 t.en ##1 1'b1 |-> ratio_r == emt_ratio_t'(3'(t.spd[0]) + 3'h1)
		|| level_r != 3'h1) else $error("ratio mismatch"); // RULE20
endmodule

// [src/emt_monitor.sv]
// Summary of operation
// RULE1 - system temperature alarm outside low/high limits, reset 0 and 60
// RULE2 - processor temperature alarm outside its own low/high limits
// RULE3 - remote temperature alarm outside its limits, routed by its delivery byte
// RULE4 - seven rails alarmed beyond plus-minus percent of nominal, reset 10
// RULE5 - one delivery byte shared by all rail alarms
// RULE6 - four general outputs, each with selectable active level
// RULE7 - forced modes hold an output at its active level regardless of alarms
// RULE8 - normal modes apply polarity and assert on routed alarm; normal-low resets
// RULE9 - monitor interrupt goes to no line, line 10 or line 11; none resets
// RULE10 - eight speed inputs, seven can act as switch inputs
// RULE11 - eighth input enables remote temperature monitoring, never a switch
// RULE12 - fan-mode input alarms below its minimum speed, reset 0
// RULE13 - switch-mode input alarms in the state chosen by its polarity
// RULE14 - every fan or switch input has its own delivery byte
// RULE15 - delivery byte enables interrupt, serial report and four outputs, all off
// RULE16 - throttling enable resets off; disabled means full ratio
// RULE17 - rising temperature at a breakpoint selects that breakpoint's ratio
// RULE18 - after a breakpoint, the next one is the upper limit
// RULE19 - faster ratio returns only below the preceding breakpoint
// RULE20 - breakpoint speeds are three quarters, half, quarter or eighth
// RULE21 - breakpoint values are whole degrees Celsius
// RULE22 - throttling notifies via interrupt, outputs or serial report as enabled
// RULE23 - software should give the second breakpoint the slowest ratio
// RULE24 - each notification asserts while any enabled item holds an alarm
// RULE25 - alarms follow the value: set while outside, clear once inside
module emt_monitor (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	input wire logic [7:0] sys_temp_i,
	input wire logic [7:0] cpu_temp_i,
	input wire logic [7:0] remote_temp_i,
	input wire emt_pkg::emt_rails_t rail_mv_i,
	input wire emt_pkg::emt_speeds_t fan_speed_i,
	input wire logic [6:0] switch_i,
	output logic irq10_o,
	output logic irq11_o,
	output logic com_report_o,
	output logic [3:0] general_purpose_output_o,
	output emt_pkg::emt_ratio_t clk_ratio_o
);
	import emt_pkg::*;
	// -------------------------------------------------------------
	// declarations
	// -------------------------------------------------------------
	emt_bus_t bus_st_r;
	logic [7:0] addr_r;
	logic wr_r;
	logic hreadyout_r;
	logic [31:0] hrdata_r;
	logic hresp_r;
	logic accept;
	logic wr_stb;
	logic fan_sel;
	logic [FAN_AW-1:0] fan_idx;
	logic [31:0] rd_mux;
	logic [31:0] status_w;
	logic [2:0] ctrl_r;
	logic [7:0] gp_mode_r;
	logic [15:0] sys_lim_r;
	logic [15:0] cpu_lim_r;
	logic [15:0] rem_lim_r;
	logic [7:0] tol_r;
	logic [31:0] dlv_r;
	logic [DLV_W-1:0] thr_dlv_r;
	logic [14:0] fan_mode_r;
	logic [31:0] bp_r;
	logic [7:0] spd_r;
	logic sys_alm_r;
	logic cpu_alm_r;
	logic rem_alm_r;
	logic volt_alm_r;
	logic [NUM_RAILS-1:0] rail_bad_r;
	logic [FAN_AW-1:0] scan_r;
	logic [FAN_AW-1:0] scan_d_r;
	logic [FAN_W-1:0] fan_q;
	logic [FAN_W-1:0] bus_q;
	logic [NUM_FANS-1:0] fan_alm_r;
	logic [NUM_FANS-1:0][DLV_W-1:0] fan_route_r;
	logic fan_alm_nxt;
	logic [DLV_W-1:0] req_nxt;
	logic [DLV_W-1:0] req_r;
	logic irq10_r;
	logic irq11_r;
	logic com_r;
	logic [NUM_GP-1:0] gp_out_r;
	emt_thr_if thr ();
	// -------------------------------------------------------------
	// AHB-Lite slave: two wait states on every NONSEQ word transfer; other transfers are ignored
	// -------------------------------------------------------------
	assign accept = hsel_i && hready_i && htrans_i == HTRANS_NONSEQ && hsize_i == HSIZE_WORD;
	assign wr_stb = bus_st_r == BUS_WAIT && wr_r;
	assign fan_sel = addr_r >= OFF_FAN0 && addr_r <= OFF_FAN_END;
	assign fan_idx = FAN_AW'((addr_r - OFF_FAN0) >> 2);
	// the extra wait lets the fan memory register its read word
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			bus_st_r <= BUS_IDLE;
			addr_r <= 8'h00;
			wr_r <= 1'b0;
			hreadyout_r <= 1'b1;
			hrdata_r <= 32'h00000000;
		end else begin
			unique case (bus_st_r)
				BUS_IDLE: begin
					if (accept) begin
						addr_r <= haddr_i[7:0];
						wr_r <= hwrite_i;
						hreadyout_r <= 1'b0;
						bus_st_r <= BUS_WAIT;
					end
				end
				BUS_WAIT: begin
					bus_st_r <= BUS_DONE;
				end
				BUS_DONE: begin
					hrdata_r <= wr_r ? 32'h00000000 : rd_mux;
					hreadyout_r <= 1'b1;
					bus_st_r <= BUS_IDLE;
				end
				default: begin
					bus_st_r <= BUS_IDLE;
					hreadyout_r <= 1'b1;
				end
			endcase
		end
	end
	// response is always okay
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			hresp_r <= HRESP_OKAY;
		end else begin
			hresp_r <= HRESP_OKAY;
		end
	end
	// status word: live alarms, throttle level, pending requests
	always_comb begin
		status_w = 32'h00000000;
		status_w[0] = sys_alm_r;
		status_w[1] = cpu_alm_r;
		status_w[2] = rem_alm_r;
		status_w[3] = volt_alm_r;
		status_w[4] = thr.level != 3'h0;
		status_w[ST_LVL_LSB +: 3] = thr.level;
		status_w[ST_RAIL_LSB +: NUM_RAILS] = rail_bad_r;
		status_w[ST_FAN_LSB +: NUM_FANS] = fan_alm_r;
		status_w[ST_REQ_LSB +: DLV_W] = req_r;
	end
	// read decode; unmapped words read zero
	always_comb begin
		rd_mux = 32'h00000000;
		if (fan_sel) begin
			rd_mux = 32'(bus_q);
		end else begin
			case (addr_r)
				OFF_CTRL: rd_mux = 32'(ctrl_r);
				OFF_GP_MODE: rd_mux = 32'(gp_mode_r);
				OFF_SYS_LIM: rd_mux = 32'(sys_lim_r);
				OFF_CPU_LIM: rd_mux = 32'(cpu_lim_r);
				OFF_REM_LIM: rd_mux = 32'(rem_lim_r);
				OFF_TOL: rd_mux = 32'(tol_r);
				OFF_DLV: rd_mux = dlv_r;
				OFF_THR_DLV: rd_mux = 32'(thr_dlv_r);
				OFF_FAN_MODE: rd_mux = 32'(fan_mode_r);
				OFF_STATUS: rd_mux = status_w;
				OFF_BP: rd_mux = bp_r;
				OFF_SPD: rd_mux = 32'(spd_r);
				default: rd_mux = 32'h00000000;
			endcase
		end
	end
	// -------------------------------------------------------------
	// configuration registers, written in the data phase
	// -------------------------------------------------------------
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ctrl_r <= {1'b0, IRQ_NONE}; // RULE9 RULE16
			gp_mode_r <= {4{GP_NLOW}}; // RULE8
			sys_lim_r <= LIM_RST; // RULE1
			cpu_lim_r <= LIM_RST;
			rem_lim_r <= LIM_RST;
			tol_r <= TOL_RST; // RULE4
			dlv_r <= 32'h00000000; // RULE15
			thr_dlv_r <= '0;
			fan_mode_r <= '0;
			bp_r <= BP_RST;
			spd_r <= SPD_RST;
		end else if (wr_stb) begin
			case (addr_r)
				OFF_CTRL: ctrl_r <= hwdata_i[2:0];
				OFF_GP_MODE: gp_mode_r <= hwdata_i[7:0];
				OFF_SYS_LIM: sys_lim_r <= hwdata_i[15:0];
				OFF_CPU_LIM: cpu_lim_r <= hwdata_i[15:0];
				OFF_REM_LIM: rem_lim_r <= hwdata_i[15:0];
				OFF_TOL: tol_r <= hwdata_i[7:0];
				OFF_DLV: dlv_r <= hwdata_i;
				OFF_THR_DLV: thr_dlv_r <= hwdata_i[DLV_W-1:0];
				OFF_FAN_MODE: fan_mode_r <= hwdata_i[14:0];
				OFF_BP: bp_r <= hwdata_i;
				OFF_SPD: spd_r <= hwdata_i[7:0];
				default: ;
			endcase
		end
	end
	// per-input words live in a small memory, scanned in turn
	emt_fan_mem u_fan_mem (
		.core_clk_i(core_clk_i),
		.rst_n_i(rst_n_i),
		.wr_en_i(wr_stb && fan_sel),
		.wr_addr_i(fan_idx),
		.wr_data_i(hwdata_i[FAN_W-1:0]),
		.scan_addr_i(scan_r),
		.scan_data_o(fan_q),
		.bus_addr_i(fan_idx),
		.bus_data_o(bus_q)
	);
	// -------------------------------------------------------------
	// temperature and rail comparators
	// -------------------------------------------------------------
	// level alarms, recomputed every clock so they clear by themselves
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sys_alm_r <= 1'b0;
			cpu_alm_r <= 1'b0;
			rem_alm_r <= 1'b0;
		end else begin
			sys_alm_r <= out_of_range(sys_temp_i, sys_lim_r[7:0], sys_lim_r[15:8]); // RULE1 RULE25
			cpu_alm_r <= out_of_range(cpu_temp_i, cpu_lim_r[7:0], cpu_lim_r[15:8]); // RULE2
			rem_alm_r <= fan_mode_r[FM_REM_EN] && // RULE11
				out_of_range(remote_temp_i, rem_lim_r[7:0], rem_lim_r[15:8]); // RULE3
		end
	end
	// one tolerance for all rails; any bad rail sets the shared alarm
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rail_bad_r <= '0;
			volt_alm_r <= 1'b0;
		end else begin
			for (int i = 0; i < NUM_RAILS; i++) begin
				rail_bad_r[i] <= rail_bad(rail_mv_i[i], RAIL_NOM[i], tol_r); // RULE4
			end
			volt_alm_r <= |rail_bad_r;
		end
	end
	// -------------------------------------------------------------
	// fan / switch scanner
	// -------------------------------------------------------------
	// a shared comparator trades eight cycles of latency for area
	always_comb begin
		fan_alm_nxt = fan_speed_i[scan_d_r] < fan_q[7:0]; // RULE12
		if (scan_d_r < FAN_AW'(NUM_SW) && fan_mode_r[scan_d_r]) begin
			fan_alm_nxt = switch_i[scan_d_r] == fan_mode_r[FM_POL_LSB + 32'(scan_d_r)]; // RULE10 RULE13
		end else if (scan_d_r == FAN_AW'(FM_REM_EN) && fan_mode_r[FM_REM_EN]) begin
			fan_alm_nxt = 1'b0; // RULE11
		end
	end
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			scan_r <= '0;
			scan_d_r <= '0;
			fan_alm_r <= '0;
			fan_route_r <= '0;
		end else begin
			scan_r <= scan_r + FAN_AW'(1);
			scan_d_r <= scan_r;
			fan_alm_r[scan_d_r] <= fan_alm_nxt;
			fan_route_r[scan_d_r] <= fan_alm_nxt ? fan_q[FAN_DLV_LSB +: DLV_W] : '0; // RULE14
		end
	end
	// -------------------------------------------------------------
	// throttle
	// -------------------------------------------------------------
	assign thr.en = ctrl_r[CTRL_THR_EN];
	assign thr.bp = bp_r;
	assign thr.spd = spd_r;
	assign thr.temp = cpu_temp_i;
	emt_throttle u_throttle (
		.core_clk_i(core_clk_i),
		.rst_n_i(rst_n_i),
		.t(thr.thr)
	);
	// -------------------------------------------------------------
	// delivery and outputs
	// -------------------------------------------------------------
	// merge every alarm through its delivery byte
	always_comb begin
		req_nxt = '0;
		if (sys_alm_r) req_nxt = req_nxt | dlv_r[DLV_SYS +: DLV_W]; // RULE15 RULE24
		if (cpu_alm_r) req_nxt = req_nxt | dlv_r[DLV_CPU +: DLV_W];
		if (rem_alm_r) req_nxt = req_nxt | dlv_r[DLV_REM +: DLV_W];
		if (volt_alm_r) req_nxt = req_nxt | dlv_r[DLV_VOLT +: DLV_W]; // RULE5
		if (thr.level != 3'h0) req_nxt = req_nxt | thr_dlv_r; // RULE22
		for (int i = 0; i < NUM_FANS; i++) begin
			req_nxt = req_nxt | fan_route_r[i];
		end
	end
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			req_r <= '0;
			irq10_r <= 1'b0;
			irq11_r <= 1'b0;
			com_r <= 1'b0;
		end else begin
			req_r <= req_nxt;
			irq10_r <= req_nxt[DLV_IRQ] && ctrl_r[1:0] == IRQ_10; // RULE9
			irq11_r <= req_nxt[DLV_IRQ] && ctrl_r[1:0] == IRQ_11;
			com_r <= req_nxt[DLV_COM]; // RULE24
		end
	end
	// resets inactive: normal-low idles high
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			gp_out_r <= GP_OUT_RST;
		end else begin
			for (int i = 0; i < NUM_GP; i++) begin
				gp_out_r[i] <= gp_level(gp_mode_r[2*i +: 2], req_nxt[DLV_GP_LSB + i]); // RULE6 RULE7 RULE8
			end
		end
	end
	assign hrdata_o = hrdata_r;
	assign hreadyout_o = hreadyout_r;
	assign hresp_o = hresp_r;
	assign irq10_o = irq10_r;
	assign irq11_o = irq11_r;
	assign com_report_o = com_r;
	assign general_purpose_output_o = gp_out_r;
	assign clk_ratio_o = thr.ratio;
	// -------------------------------------------------------------
	// checks
	// -------------------------------------------------------------
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);
	sequence s_bus_req;
		bus_st_r == BUS_IDLE && accept;
	endsequence
	sequence s_bus_ans;
		!hreadyout_o ##1 !hreadyout_o ##1 hreadyout_o;
	endsequence
	a_bus_two_waits: assert property (s_bus_req |=> s_bus_ans) else $error("bus answer timing");
	a_sys_alarm_set: assert property (out_of_range(sys_temp_i, sys_lim_r[7:0], sys_lim_r[15:8])
		|=> sys_alm_r) else $error("sys alarm missing"); // RULE1
	a_sys_alarm_clear: assert property (!out_of_range(sys_temp_i, sys_lim_r[7:0], sys_lim_r[15:8])
		|=> !sys_alm_r) else $error("sys alarm stuck"); // RULE25
	a_cpu_alarm_set: assert property (cpu_temp_i > cpu_lim_r[15:8] |=> cpu_alm_r)
		else $error("cpu alarm missing"); // RULE2
	a_remote_gate_off: assert property (!fan_mode_r[FM_REM_EN] |=> !rem_alm_r)
		else $error("remote alarm while disabled"); // RULE11
	a_rail_zero_bad: assert property (rail_bad(rail_mv_i[0], RAIL_NOM[0], tol_r) |=> ##1 volt_alm_r)
		else $error("rail alarm missing"); // RULE4
	a_force_high_out: assert property (gp_mode_r[1:0] == GP_FHIGH [*2] |=> general_purpose_output_o[0])
		else $error("forced output not active"); // RULE7
	a_irq_none_quiet: assert property (ctrl_r[1:0] == IRQ_NONE |=> !irq10_o && !irq11_o)
		else $error("irq with no route"); // RULE9
	a_com_route_sys: assert property (sys_alm_r && dlv_r[DLV_SYS + DLV_COM] |=> com_report_o)
		else $error("serial report missing"); // RULE24
endmodule

// [verification/emt_sensor_model.sv]
module emt_sensor_model
	import emt_pkg::*;
(
	output logic [7:0] sys_temp_o,
	output logic [7:0] cpu_temp_o,
	output logic [7:0] remote_temp_o,
	output emt_rails_t rail_mv_o,
	output emt_speeds_t fan_speed_o,
	output logic [6:0] switch_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// readings start in range so nothing alarms straight out of reset
	initial begin
		sys_temp_o = 8'h19;
		cpu_temp_o = 8'h19;
		remote_temp_o = 8'h19;
		rail_mv_o = RAIL_NOM;
		fan_speed_o = {8{8'h64}};
		switch_o = 7'h00;
	end
	// callers sit just after an edge, so readings move off the sampling edge
	task automatic temps(input logic [7:0] s, input logic [7:0] c, input logic [7:0] r);
		sys_temp_o <= s;
		cpu_temp_o <= c;
		remote_temp_o <= r;
	endtask
	task automatic rail(input int i, input logic [15:0] mv);
		rail_mv_o[i] <= mv;
	endtask
	task automatic fan(input int i, input logic [7:0] spd, input logic [6:0] sw);
		fan_speed_o[i] <= spd;
		switch_o <= sw;
	endtask
endmodule

// [verification/test_env_monitor_thermal_throttle.sv]
module test_env_monitor_thermal_throttle;
	timeunit 1ns;
	timeprecision 1ns;
	import emt_pkg::*;
	logic clk = 1'b0, rst_n = 1'b0, hwrite = 1'b0, hready, hresp, irq10, irq11, com;
	logic [1:0] htrans = 2'b00;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
	logic [7:0] st, ct, rt;
	emt_rails_t rails;
	emt_speeds_t fans;
	logic [6:0] sw;
	logic [3:0] general_purpose_output;
	emt_ratio_t ratio;
	int bad_count = 0, compares = 0, cyc = 0;
	logic [7:0] tt [8] = '{8'd60, 8'd65, 8'd70, 8'd75, 8'd72, 8'd64, 8'd62, 8'd59};
	logic [2:0] rr [8] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h3, 3'h1, 3'h1, 3'h0};
	always #25 clk = ~clk;
	emt_sensor_model sens_u (.sys_temp_o(st), .cpu_temp_o(ct), .remote_temp_o(rt), .rail_mv_o(rails),
		.fan_speed_o(fans), .switch_o(sw));
	emt_monitor dut_u (.core_clk_i(clk), .rst_n_i(rst_n), .hsel_i(1'b1), .haddr_i(haddr), .htrans_i(htrans),
		.hwrite_i(hwrite), .hsize_i(HSIZE_WORD), .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
		.hreadyout_o(hready), .hresp_o(hresp), .sys_temp_i(st), .cpu_temp_i(ct), .remote_temp_i(rt),
		.rail_mv_i(rails), .fan_speed_i(fans), .switch_i(sw), .irq10_o(irq10), .irq11_o(irq11),
		.com_report_o(com), .general_purpose_output_o(general_purpose_output), .clk_ratio_o(ratio));
	// -------------------------------------------------------------
	// bus and compare helpers
	// -------------------------------------------------------------
	task automatic summarize();
		if (bad_count == 0 && compares > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// one single word transfer; address held until hready is seen high
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		htrans <= HTRANS_NONSEQ;
		haddr <= {24'h0, a};
		hwrite <= w;
		do @(posedge clk); while (hready !== 1'b1);
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge clk); while (hready !== 1'b1);
		rd = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		chk(rd, e);
		chk(hresp, HRESP_OKAY);
	endtask
	// fan scan is round robin, so allow the full scan before looking
	task automatic settle();
		repeat (12) @(posedge clk);
	endtask
	// hang guard well above the expected run length
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			bad_count++;
			summarize();
		end
	end
	// -------------------------------------------------------------
	// main sequence
	// -------------------------------------------------------------
	initial begin
		repeat (8) @(posedge clk);
		chk({irq10, irq11, com, general_purpose_output}, 32'h0F);
		chk(ratio, RATIO_FULL);
		rst_n <= 1'b1;
		@(posedge clk);
		rdc(OFF_CTRL, 32'h0);
		rdc(OFF_GP_MODE, 32'h0);
		rdc(OFF_SYS_LIM, 32'h3C00);
		rdc(OFF_TOL, 32'h0A);
		rdc(OFF_DLV, 32'h0);
		rdc(OFF_BP, BP_RST);
		rdc(OFF_FAN0, 32'h0);
		rdc(8'h80, 32'h0);
		wr(OFF_DLV, 32'h3F);
		wr(OFF_CTRL, 32'h1);
		sens_u.temps(8'd61, 8'd25, 8'd25);
		settle();
		chk({irq10, irq11, com, general_purpose_output}, 32'h50);
		wr(OFF_CTRL, 32'h2);
		settle();
		chk({irq10, irq11, com, general_purpose_output}, 32'h30);
		sens_u.temps(8'd60, 8'd25, 8'd25);
		settle();
		chk({irq10, irq11, com, general_purpose_output}, 32'h0F);
		// forced-high, forced-low, normal-high, normal-low on outputs 0..3
		wr(OFF_GP_MODE, 32'h1B);
		wr(OFF_DLV, 32'h3C);
		settle();
		chk(general_purpose_output, 32'h9);
		sens_u.temps(8'd61, 8'd25, 8'd25);
		settle();
		chk(general_purpose_output, 32'h5);
		sens_u.temps(8'd25, 8'd19, 8'd25);
		wr(OFF_CPU_LIM, 32'h5014);
		wr(OFF_DLV, 32'h0200);
		settle();
		chk(com, 32'h1);
		sens_u.temps(8'd25, 8'd20, 8'd70);
		wr(OFF_DLV, 32'h0202_0000);
		sens_u.rail(0, 16'd5500);
		settle();
		chk(com, 32'h0);
		sens_u.rail(3, 16'd13201);
		settle();
		chk(com, 32'h1);
		sens_u.rail(3, 16'd12000);
		sens_u.rail(0, 16'd5501);
		settle();
		chk(com, 32'h1);
		sens_u.rail(0, 16'd5000);
		wr(OFF_FAN_MODE, 32'h80);
		settle();
		chk(com, 32'h1);
		wr(OFF_DLV, 32'h0);
		wr(OFF_FAN0, 32'h0232);
		sens_u.fan(0, 8'd49, 7'h00);
		settle();
		chk(com, 32'h1);
		sens_u.fan(0, 8'd50, 7'h02);
		wr(OFF_FAN0 + 8'h04, 32'h0200);
		wr(OFF_FAN_MODE, 32'h0202);
		settle();
		chk(com, 32'h1);
		// input 0 alarms again, but its own byte now routes nowhere
		wr(OFF_FAN0, 32'h0032);
		sens_u.fan(0, 8'd49, 7'h00);
		settle();
		chk(com, 32'h0);
		wr(OFF_THR_DLV, 32'h2);
		sens_u.temps(8'd25, 8'd75, 8'd25);
		settle();
		chk(ratio, RATIO_FULL);
		wr(OFF_CTRL, 32'h4);
		for (int i = 0; i < 8; i++) begin
			sens_u.temps(8'd25, tt[i], 8'd25);
			settle();
			chk(ratio, rr[i]);
			chk(com, 32'(rr[i] != 3'h0));
		end
		// slowest ratio placed at the second breakpoint
		wr(OFF_SPD, 32'hEC);
		sens_u.temps(8'd25, 8'd66, 8'd25);
		settle();
		chk(ratio, RATIO_8TH);
		summarize();
	end
endmodule
